/* verilog/hsfs_map.svh */
// Command codes, bit positions, cause codes and reset values of the
// fault status bank.
// Assumes inclusion by bare name from the package and the design files.
`ifndef HSFS_MAP_SVH
`define HSFS_MAP_SVH

// Command codes of the three status registers
`define HSFS_CMD_INPUT_STATUS 8'h7C
`define HSFS_CMD_TEMP_STATUS 8'h7D
`define HSFS_CMD_VENDOR_STATUS 8'h80

// Reset value of every status register and of read data
`define HSFS_STATUS_RESET 8'h00
`define HSFS_ZERO_BIT 1'h0
`define HSFS_ZERO_3 3'h0
`define HSFS_ZERO_6 6'h00

// Input status bit positions
`define HSFS_IN_OV_FAULT_BIT 7
`define HSFS_IN_OV_WARN_BIT 6
`define HSFS_IN_UV_WARN_BIT 5
`define HSFS_IN_UV_FAULT_BIT 4
`define HSFS_IN_OP_WARN_BIT 0

// Temperature status bit positions
`define HSFS_OVERTEMPERATURE_FAULT_BIT 7
`define HSFS_OT_WARN_BIT 6

// Vendor status bit positions and cause field
`define HSFS_FET_HEALTH_BIT 7
`define HSFS_UV_LIVE_BIT 6
`define HSFS_OV_LIVE_BIT 5
`define HSFS_SEVERE_OC_BIT 4
`define HSFS_INLIM_BIT 3

// Shutdown cause codes
`define HSFS_CAUSE_NONE 3'h0
`define HSFS_CAUSE_OT 3'h1
`define HSFS_CAUSE_OC 3'h2
`define HSFS_CAUSE_FET 3'h3
`define HSFS_CAUSE_UV 3'h4
`define HSFS_CAUSE_OV 3'h6

// Hot swap state codes
`define HSFS_ST_RUN 2'h0
`define HSFS_ST_FAULT_OFF 2'h1
`define HSFS_ST_CMD_OFF 2'h2

`endif

/* verilog/hsfs_pkg.sv */
// Types of the fault status bank.
// Assumes the map header is on the include path.
`default_nettype none
`include "hsfs_map.svh"

package hsfs_pkg;

  typedef enum logic [2:0] {
    CAUSE_NONE = `HSFS_CAUSE_NONE,
    CAUSE_OT = `HSFS_CAUSE_OT,
    CAUSE_OC = `HSFS_CAUSE_OC,
    CAUSE_FET = `HSFS_CAUSE_FET,
    CAUSE_UV = `HSFS_CAUSE_UV,
    CAUSE_OV = `HSFS_CAUSE_OV
  } hsfs_cause_t;

  typedef enum logic [1:0] {
    ST_RUN = `HSFS_ST_RUN,
    ST_FAULT_OFF = `HSFS_ST_FAULT_OFF,
    ST_CMD_OFF = `HSFS_ST_CMD_OFF
  } hsfs_state_t;

endpackage
`default_nettype wire

/* verilog/hsfs_sticky.sv */
// One latched status flag: set wins over clear.
// Assumes set and clear come from logic on mclk.
`timescale 1ns/10ps
`default_nettype none
`include "hsfs_map.svh"

module hsfs_sticky (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic set,
  input wire logic clr,
  // Flag
  output logic q
);

  logic q_next;

  assign q_next = set | (q & ~clr);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= `HSFS_ZERO_BIT;
    end else begin
      q <= q_next;
    end
  end

endmodule // hsfs_sticky
`default_nettype wire

/* verilog/hsfs_sync2.sv */
// Two flip-flop synchroniser for a pin level.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
`include "hsfs_map.svh"

module hsfs_sync2 (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Level
  input wire logic d,
  output logic q
);

  logic meta_reg;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta_reg <= `HSFS_ZERO_BIT;
      q <= `HSFS_ZERO_BIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule // hsfs_sync2
`default_nettype wire

/* verilog/hsfs_status_bank.sv */
// Hot swap fault status bank: input, temperature and vendor status
// registers read by command code, with shutdown cause tracking.
// Assumes detector strobes are on mclk; comparator pins are async.
//
// Function
// - OV pin overvoltage latches input bit 7
// - Monitor overvoltage warning latches input bit 6
// - Monitor undervoltage warning latches input bit 5
// - UV pin undervoltage latches input bit 4
// - Monitor overpower warning latches input bit 0
// - Reserved input and temperature bits read zero
// - Overtemperature fault latches temperature bit 7
// - Overtemperature warning latches temperature bit 6
// - Pass transistor health latches vendor bit 7
// - Vendor bit 6 follows UV comparator live
// - Vendor bit 5 follows OV comparator live
// - Severe overcurrent latches vendor bit 4
// - Limiting latches bit 3; overcurrent after timer
// - Cause of last shutdown held until clear faults or operation off
// - Cause reads zero when command off; kept when operation on rearms
// - Cause codes: OT, OC, FET, UV, OV
// - All three registers reset to zero
// - Input summary live when any input bit
// - Vendor summary live when any vendor bit
`timescale 1ns/10ps
`default_nettype none
`include "hsfs_map.svh"

module hsfs_status_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Comparator pins, asynchronous
  input wire logic uv_cmp_pin,
  input wire logic ov_cmp_pin,
  // Power monitor detector strobes
  input wire logic ov_warn_det,
  input wire logic uv_warn_det,
  input wire logic op_warn_det,
  input wire logic overtemperature_fault_det,
  input wire logic ot_warn_det,
  // Hot swap detector strobes
  input wire logic fet_health_det,
  input wire logic severe_oc_det,
  input wire logic inlim_det,
  input wire logic timer_expired,
  // Operation command and clear faults command
  input wire logic operation_on,
  input wire logic operation_off,
  input wire logic clear_faults,
  // Register read port
  input wire logic rd_strobe,
  input wire logic [7:0] rd_cmd,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic rd_unsupported,
  // Summary and control outputs
  output logic input_summary_flag,
  output logic vendor_summary_flag,
  output logic output_overcurrent_fault,
  output logic hot_swap_enabled
);

  ////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers

  logic uv_cmp_sync;
  logic ov_cmp_sync;

  hsfs_sync2 u_uv_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d(uv_cmp_pin),
    .q(uv_cmp_sync)
  );

  hsfs_sync2 u_ov_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d(ov_cmp_pin),
    .q(ov_cmp_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Input status flags

  logic input_overvoltage_fault;
  logic input_overvoltage_warning;
  logic input_undervoltage_warning;
  logic input_undervoltage_fault;
  logic input_overpower_warning;

  hsfs_sticky u_in_ov_fault (
    .mclk(mclk),
    .rstn(rstn),
    .set(ov_cmp_sync),
    .clr(clear_faults),
    .q(input_overvoltage_fault)
  );

  hsfs_sticky u_in_ov_warn (
    .mclk(mclk),
    .rstn(rstn),
    .set(ov_warn_det),
    .clr(clear_faults),
    .q(input_overvoltage_warning)
  );

  hsfs_sticky u_in_uv_warn (
    .mclk(mclk),
    .rstn(rstn),
    .set(uv_warn_det),
    .clr(clear_faults),
    .q(input_undervoltage_warning)
  );

  hsfs_sticky u_in_uv_fault (
    .mclk(mclk),
    .rstn(rstn),
    .set(uv_cmp_sync),
    .clr(clear_faults),
    .q(input_undervoltage_fault)
  );

  hsfs_sticky u_in_op_warn (
    .mclk(mclk),
    .rstn(rstn),
    .set(op_warn_det),
    .clr(clear_faults),
    .q(input_overpower_warning)
  );

  ////////////////////////////////////////////////////////////////////////
  // Temperature status flags

  logic overtemperature_fault;
  logic overtemperature_warning;

  hsfs_sticky u_overtemperature_fault (
    .mclk(mclk),
    .rstn(rstn),
    .set(overtemperature_fault_det),
    .clr(clear_faults),
    .q(overtemperature_fault)
  );

  hsfs_sticky u_ot_warn (
    .mclk(mclk),
    .rstn(rstn),
    .set(ot_warn_det),
    .clr(clear_faults),
    .q(overtemperature_warning)
  );

  ////////////////////////////////////////////////////////////////////////
  // Vendor status flags

  logic pass_transistor_health_fault;
  logic severe_overcurrent_fault;
  logic current_limiting_active_fault;

  hsfs_sticky u_fet_health (
    .mclk(mclk),
    .rstn(rstn),
    .set(fet_health_det),
    .clr(clear_faults),
    .q(pass_transistor_health_fault)
  );

  hsfs_sticky u_severe_oc (
    .mclk(mclk),
    .rstn(rstn),
    .set(severe_oc_det),
    .clr(clear_faults),
    .q(severe_overcurrent_fault)
  );

  // Set at the start of limiting, before the timer runs out
  hsfs_sticky u_inlim (
    .mclk(mclk),
    .rstn(rstn),
    .set(inlim_det),
    .clr(clear_faults),
    .q(current_limiting_active_fault)
  );

  // Output overcurrent only once the timer has expired
  hsfs_sticky u_out_oc (
    .mclk(mclk),
    .rstn(rstn),
    .set(timer_expired),
    .clr(clear_faults),
    .q(output_overcurrent_fault)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shutdown cause selection, highest priority first

  logic trip_ov;
  logic trip_uv;
  logic trip_fet;
  logic trip_oc;
  logic trip_ot;
  logic trip_any;
  hsfs_pkg::hsfs_cause_t trip_cause;

  assign trip_ov = ov_cmp_sync;
  assign trip_uv = uv_cmp_sync;
  assign trip_fet = fet_health_det;
  assign trip_oc = timer_expired;
  assign trip_ot = overtemperature_fault_det;
  assign trip_any = trip_ov | trip_uv | trip_fet | trip_oc | trip_ot;

  assign trip_cause =
    trip_ov ? hsfs_pkg::CAUSE_OV :
    trip_uv ? hsfs_pkg::CAUSE_UV :
    trip_fet ? hsfs_pkg::CAUSE_FET :
    trip_oc ? hsfs_pkg::CAUSE_OC :
    trip_ot ? hsfs_pkg::CAUSE_OT :
    hsfs_pkg::CAUSE_NONE;

  ////////////////////////////////////////////////////////////////////////
  // Hot swap state and cause field

  hsfs_pkg::hsfs_state_t state_reg;
  hsfs_pkg::hsfs_state_t state_next;
  hsfs_pkg::hsfs_cause_t cause_reg;
  hsfs_pkg::hsfs_cause_t cause_next;

  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    case (state_reg)
      hsfs_pkg::ST_RUN: begin
        if (operation_off) begin
          state_next = hsfs_pkg::ST_CMD_OFF;
          cause_next = hsfs_pkg::CAUSE_NONE;
        end else if (trip_any) begin
          state_next = hsfs_pkg::ST_FAULT_OFF;
          cause_next = trip_cause;
        end else if (clear_faults) begin
          cause_next = hsfs_pkg::CAUSE_NONE;
        end
      end
      hsfs_pkg::ST_FAULT_OFF: begin
        if (operation_off) begin
          state_next = hsfs_pkg::ST_CMD_OFF;
          cause_next = hsfs_pkg::CAUSE_NONE;
        end else if (clear_faults) begin
          // Rearm; a fault still present trips again next cycle
          state_next = hsfs_pkg::ST_RUN;
          cause_next = hsfs_pkg::CAUSE_NONE;
        end else if (operation_on) begin
          state_next = hsfs_pkg::ST_RUN;
        end
      end
      hsfs_pkg::ST_CMD_OFF: begin
        cause_next = hsfs_pkg::CAUSE_NONE;
        if (operation_on) begin
          state_next = hsfs_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = hsfs_pkg::ST_RUN;
        cause_next = hsfs_pkg::CAUSE_NONE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= hsfs_pkg::ST_RUN;
      cause_reg <= hsfs_pkg::CAUSE_NONE;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
    end
  end

  assign hot_swap_enabled = (state_reg == hsfs_pkg::ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Register images

  logic [7:0] input_status_byte;
  logic [7:0] temp_status_byte;
  logic [7:0] vendor_status_byte;

  assign input_status_byte = {
    input_overvoltage_fault,
    input_overvoltage_warning,
    input_undervoltage_warning,
    input_undervoltage_fault,
    `HSFS_ZERO_3,
    input_overpower_warning
  };

  assign temp_status_byte = {
    overtemperature_fault,
    overtemperature_warning,
    `HSFS_ZERO_6
  };

  assign vendor_status_byte = {
    pass_transistor_health_fault,
    uv_cmp_sync,
    ov_cmp_sync,
    severe_overcurrent_fault,
    current_limiting_active_fault,
    cause_reg
  };

  // Live summaries for the status word
  assign input_summary_flag = |input_status_byte;
  assign vendor_summary_flag = |vendor_status_byte;

  ////////////////////////////////////////////////////////////////////////
  // Read decode

  logic sel_input;
  logic sel_temp;
  logic sel_vendor;
  logic sel_hit;
  logic [7:0] rd_data_next;

  assign sel_input = (rd_cmd == `HSFS_CMD_INPUT_STATUS);
  assign sel_temp = (rd_cmd == `HSFS_CMD_TEMP_STATUS);
  assign sel_vendor = (rd_cmd == `HSFS_CMD_VENDOR_STATUS);
  assign sel_hit = sel_input | sel_temp | sel_vendor;

  assign rd_data_next =
    sel_input ? input_status_byte :
    sel_temp ? temp_status_byte :
    sel_vendor ? vendor_status_byte :
    `HSFS_STATUS_RESET;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_data <= `HSFS_STATUS_RESET;
      rd_valid <= `HSFS_ZERO_BIT;
      rd_unsupported <= `HSFS_ZERO_BIT;
    end else begin
      rd_valid <= rd_strobe;
      rd_unsupported <= rd_strobe & ~sel_hit;
      if (rd_strobe) begin
        rd_data <= rd_data_next;
      end
    end
  end

endmodule // hsfs_status_bank
`default_nettype wire

/* dv/hsfs_status_bank_monitor.sv */
// Port checker for the fault status bank.
// Assumes it is bound to hsfs_status_bank with all ports visible.
`timescale 1ns/10ps
`default_nettype none

module hsfs_status_bank_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Stimulus seen
  input wire logic timer_expired,
  input wire logic operation_on,
  input wire logic operation_off,
  input wire logic clear_faults,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_cmd,
  // Responses seen
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_unsupported,
  input wire logic output_overcurrent_fault,
  input wire logic hot_swap_enabled
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Tracks a shutdown by command, which clear faults must not undo
  logic cmd_off_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_off_reg <= 1'h0;
    end else if (cmd_off_reg) begin
      cmd_off_reg <= !operation_on;
    end else begin
      cmd_off_reg <= operation_off;
    end
  end

  a_read_answer_time: assert property (rd_strobe |=> rd_valid)
    else $error("read not answered in one cycle");
  a_valid_has_cause: assert property (rd_valid |-> $past(rd_strobe))
    else $error("read valid without request");
  a_unsup_reads_zero: assert property (
    rd_unsupported |-> rd_valid && rd_data == 8'h00)
    else $error("unknown code answered badly");
  a_input_rsvd_zero: assert property (
    rd_valid && $past(rd_cmd) == 8'h7C |-> rd_data[3:1] == 3'h0)
    else $error("input reserved bits set");
  a_temp_rsvd_zero: assert property (
    rd_valid && $past(rd_cmd) == 8'h7D |-> rd_data[5:0] == 6'h00)
    else $error("temperature reserved bits set");
  a_oc_after_timer: assert property (
    $rose(output_overcurrent_fault) |-> $past(timer_expired))
    else $error("overcurrent fault without timer");
  a_timer_sets_oc: assert property (
    timer_expired |=> output_overcurrent_fault)
    else $error("timer did not set overcurrent fault");
  a_trip_shuts_down: assert property (
    hot_swap_enabled && timer_expired && !operation_off && !clear_faults
    ##1 !clear_faults && !operation_on
    |-> !hot_swap_enabled ##1 !hot_swap_enabled)
    else $error("trip did not shut down");
  a_clear_rearms: assert property (
    clear_faults && !operation_off && !hot_swap_enabled && !cmd_off_reg
    |=> hot_swap_enabled)
    else $error("clear did not rearm");
  a_cmd_off_holds: assert property (
    cmd_off_reg |-> !hot_swap_enabled)
    else $error("command shutdown not held");
  a_off_disables: assert property (
    operation_off && !clear_faults && !operation_on |=> !hot_swap_enabled)
    else $error("operation off ignored");

  c_unsup: cover property (rd_unsupported);
  c_trip: cover property (hot_swap_enabled ##1 !hot_swap_enabled);
  c_off: cover property (operation_off);
endmodule // hsfs_status_bank_monitor

bind hsfs_status_bank hsfs_status_bank_monitor hsfs_status_bank_monitor_i (
  .mclk(mclk), .rstn(rstn), .timer_expired(timer_expired),
  .operation_on(operation_on), .operation_off(operation_off),
  .clear_faults(clear_faults), .rd_strobe(rd_strobe), .rd_cmd(rd_cmd),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_unsupported(rd_unsupported),
  .output_overcurrent_fault(output_overcurrent_fault),
  .hot_swap_enabled(hot_swap_enabled));

`default_nettype wire

/* dv/hsfs_host.sv */
// Host model: reads status by command code and sends clear faults.
// Assumes the read port contract of the bank on mclk.
`timescale 1ns/10ps
`default_nettype none

module hsfs_host (
  // Clock
  input wire logic mclk,
  // Read port
  output var logic rd_strobe,
  output var logic [7:0] rd_cmd,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_unsupported,
  // Clear faults command
  output var logic clear_faults
);
  initial begin
    rd_strobe = 1'h0;
    rd_cmd = 8'h00;
    clear_faults = 1'h0;
  end

  // Request held until the taking edge, answer taken at rd_valid
  task automatic read(input logic [7:0] c, output logic [7:0] d,
                      output logic u);
    d = 8'hFF;
    u = 1'h1;
    @(posedge mclk);
    rd_strobe <= 1'h1;
    rd_cmd <= c;
    @(posedge mclk);
    rd_strobe <= 1'h0;
    rd_cmd <= ~c;
    repeat (4) begin
      @(posedge mclk);
      if (rd_valid === 1'h1) begin
        d = rd_data;
        u = rd_unsupported;
        break;
      end
    end
  endtask

  task automatic clear();
    @(posedge mclk);
    clear_faults <= 1'h1;
    @(posedge mclk);
    clear_faults <= 1'h0;
  endtask
endmodule // hsfs_host

`default_nettype wire

/* dv/tb.sv */
// Self-checking bench of the fault status bank.
// Assumes hsfs_host model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic uv_pin = 1'h0;
  logic ov_pin = 1'h0;
  logic [10:0] det = 11'h000;
  logic rd_strobe, rd_valid, rd_unsupported, clear_faults;
  logic [7:0] rd_cmd, rd_data, d;
  logic u, in_sum, ven_sum, out_oc, en;
  int error_cnt = 0;
  int checks_done = 0;
  int idx[9] = '{0, 1, 2, 4, 6, 7, 3, 5, 8};
  logic [7:0] cmd[9] = '{8'h7C, 8'h7C, 8'h7C, 8'h7D, 8'h80, 8'h80,
                         8'h7D, 8'h80, 8'h80};
  logic [7:0] ex[9] = '{8'h40, 8'h20, 8'h01, 8'h40, 8'h10, 8'h08,
                        8'h80, 8'h83, 8'h02};
  logic [7:0] vx[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h08,
                        8'h01, 8'h83, 8'h02};

  initial forever #20 mclk = ~mclk;

  hsfs_host hsfs_host_i (.mclk(mclk), .rd_strobe(rd_strobe),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_unsupported(rd_unsupported), .clear_faults(clear_faults));

  hsfs_status_bank hsfs_status_bank_i (.mclk(mclk), .rstn(rstn),
    .uv_cmp_pin(uv_pin), .ov_cmp_pin(ov_pin), .ov_warn_det(det[0]),
    .uv_warn_det(det[1]), .op_warn_det(det[2]), .overtemperature_fault_det(det[3]),
    .ot_warn_det(det[4]), .fet_health_det(det[5]),
    .severe_oc_det(det[6]), .inlim_det(det[7]), .timer_expired(det[8]),
    .operation_on(det[9]), .operation_off(det[10]),
    .clear_faults(clear_faults), .rd_strobe(rd_strobe), .rd_cmd(rd_cmd),
    .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_unsupported(rd_unsupported), .input_summary_flag(in_sum),
    .vendor_summary_flag(ven_sum), .output_overcurrent_fault(out_oc),
    .hot_swap_enabled(en));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    hsfs_host_i.read(c, d, u);
    chk(d, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge mclk);
    det[i] <= 1'h1;
    @(posedge mclk);
    det[i] <= 1'h0;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'h1;
    rd(8'h7C, 8'h00);
    rd(8'h7D, 8'h00);
    rd(8'h80, 8'h00);
    chk({7'h00, en}, 8'h01);
    rd(8'h81, 8'h00);
    chk({7'h00, u}, 8'h01);
    // Each detector alone, then clear
    for (int k = 0; k < 9; k++) begin
      pulse(idx[k]);
      rd(cmd[k], ex[k]);
      rd(8'h80, vx[k]);
      chk({7'h00, en}, {7'h00, vx[k][2:0] == 3'h0});
      chk({7'h00, in_sum}, {7'h00, cmd[k] == 8'h7C});
      chk({7'h00, ven_sum}, {7'h00, vx[k] != 8'h00});
      chk({7'h00, out_oc}, {7'h00, idx[k] == 8});
      hsfs_host_i.clear();
      rd(cmd[k], 8'h00);
      chk({7'h00, en}, 8'h01);
    end
    // Both comparator pins: OV cause wins, live bits follow
    @(posedge mclk);
    uv_pin <= 1'h1;
    ov_pin <= 1'h1;
    repeat (4) @(posedge mclk);
    rd(8'h7C, 8'h90);
    rd(8'h80, 8'h66);
    uv_pin <= 1'h0;
    ov_pin <= 1'h0;
    repeat (4) @(posedge mclk);
    rd(8'h80, 8'h06);
    hsfs_host_i.clear();
    rd(8'h7C, 8'h00);
    rd(8'h80, 8'h00);
    // UV pin alone: undervoltage cause
    @(posedge mclk);
    uv_pin <= 1'h1;
    repeat (4) @(posedge mclk);
    rd(8'h7C, 8'h10);
    rd(8'h80, 8'h44);
    chk({7'h00, in_sum}, 8'h01);
    uv_pin <= 1'h0;
    repeat (4) @(posedge mclk);
    hsfs_host_i.clear();
    rd(8'h80, 8'h00);
    // Condition still present reloads after clear
    @(posedge mclk);
    det[4] <= 1'h1;
    hsfs_host_i.clear();
    rd(8'h7D, 8'h40);
    det[4] <= 1'h0;
    hsfs_host_i.clear();
    rd(8'h7D, 8'h00);
    // Cause held against later trip, then operation off and on
    pulse(8);
    pulse(5);
    rd(8'h80, 8'h82);
    pulse(10);
    rd(8'h80, 8'h80);
    chk({7'h00, en}, 8'h00);
    pulse(9);
    rd(8'h80, 8'h80);
    chk({7'h00, en}, 8'h01);
    hsfs_host_i.clear();
    rd(8'h80, 8'h00);
    stop_test();
  end
endmodule // tb

`default_nettype wire
